// file: design/sec_event_gate.sv
// Event capture flags, summary, receive-pin alert and sleep entry gate.
// Overview of operation
// - No enabled wake source: refuse sleep, reset system
// - Sleep command with pending flag: go Reset
// - Sleep disabled: sleep command is serial failure
// - Sleep disable comes from nonvolatile configuration
// - Read-only summary at 0x60, bits 3:0
// - System bit 4: left Off mode
// - System bit 2: overtemperature warning
// - System bit 1 serial, bit 0 watchdog
// - Supply flags: sensor over, under, controller under
// - Transceiver bit 4: bus silence timeout
// - Transceiver bit 1: transceiver deactivated
// - Transceiver bit 0: bus wake while offline
// - Pin register: rising and falling edge flags
// - Capture enable 0x04: bits 2,1 writable
// - Write one clears, zero leaves unchanged
// - Flags set only when capture enabled, except power-on and watchdog
// - Receive output low on pending while offline and controller supply on
`timescale 1ns/1ns
`default_nettype none
`include "sec_consts.svh"
module sec_event_gate
  import sec_pkg::*;
#(
  parameter bit HAS_SENSOR_SUPPLY = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       mode_wr,
  input  wire logic [2:0] operating_mode_field,
  input  wire logic       sleep_disable_config,
  input  wire logic       poweron_evt,
  input  wire logic       watchdog_fail_evt,
  input  wire logic       serial_fail_evt,
  input  wire logic       overheat_in,
  input  wire logic       controller_uv_in,
  input  wire logic       sensor_ov_in,
  input  wire logic       sensor_uv_in,
  input  wire logic       bus_silent_in,
  input  wire logic       trx_deactivated_in,
  input  wire logic       bus_wake_in,
  input  wire logic       wake_pin,
  input  wire logic       trx_offline,
  input  wire logic       controller_supply_on,
  input  wire logic [2:0] supply_capture_en,
  input  wire logic       bus_silence_capture_en,
  input  wire logic       trx_fault_capture_en,
  input  wire logic       bus_wake_capture_en,
  input  wire logic       pin_rise_capture_en,
  input  wire logic       pin_fall_capture_en,
  output logic            sleep_enter,
  output logic            reset_enter,
  output logic            rxd
);
  // Analog detector outputs and the wake pin arrive without regard to clk_sys.
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic       pin_prev_q;
  logic [7:0] cap_en_q;
  logic [7:0] rdata_q;
  logic       sleep_q;
  logic       rst_q;
  logic       rxd_q;
  logic       cmd_serial_failure_flag;
  logic       any_pending;
  logic       wake_src_on;
  logic [7:0] summary;
  logic [7:0] sup_mask;
  logic [7:0] sys_set;
  logic [7:0] sup_set;
  logic [7:0] trx_set;
  logic [7:0] pin_set;
  logic       pin_now;
  sec_verdict_t verdict;

  sec_flag_if sys_if ();
  sec_flag_if sup_if ();
  sec_flag_if trx_if ();
  sec_flag_if pin_if ();

  sec_flag_reg u_sys (.clk_sys(clk_sys), .reset(reset), .fl(sys_if));
  sec_flag_reg u_sup (.clk_sys(clk_sys), .reset(reset), .fl(sup_if));
  sec_flag_reg u_trx (.clk_sys(clk_sys), .reset(reset), .fl(trx_if));
  sec_flag_reg u_pin (.clk_sys(clk_sys), .reset(reset), .fl(pin_if));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {wake_pin, bus_wake_in, trx_deactivated_in, bus_silent_in,
                  sensor_ov_in, sensor_uv_in, controller_uv_in, overheat_in};
      sync2_q <= sync1_q;
    end
  end

  assign pin_now = sync2_q[7];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_now;
    end
  end

  // Capture enable register: only the two defined bits ever hold a one.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cap_en_q <= `SEC_CAP_EN_RESET;
    end else if (reg_wr && reg_addr == `SEC_ADDR_SYS_CAP_EN) begin
      cap_en_q <= reg_wdata & `SEC_CAP_EN_MASK;
    end
  end

  assign sup_mask = HAS_SENSOR_SUPPLY ? `SEC_SUP_MASK_FULL : `SEC_SUP_MASK_BASIC;

  // Sleep verdict, in order of precedence: disabled, no wake source, pending.
  assign wake_src_on = bus_wake_capture_en | pin_rise_capture_en | pin_fall_capture_en;
  assign any_pending = |summary[3:0];

  always_comb begin
    verdict = SEC_V_NONE;
    if (mode_wr && operating_mode_field == `SEC_MODE_SLEEP) begin
      if (sleep_disable_config) begin
        verdict = SEC_V_SPIFAIL;
      end else if (!wake_src_on) begin
        verdict = SEC_V_RESET;
      end else if (any_pending) begin
        verdict = SEC_V_RESET;
      end else begin
        verdict = SEC_V_SLEEP;
      end
    end
  end

  assign cmd_serial_failure_flag = (verdict == SEC_V_SPIFAIL);

  // Event sets, each gated by its capture enable; power-on and watchdog always.
  always_comb begin
    sys_set = 8'h00;
    sys_set[`SEC_SYS_PO_BIT]   = poweron_evt;
    sys_set[`SEC_SYS_OTW_BIT]  = sync2_q[0] & cap_en_q[`SEC_SYS_OTW_BIT];
    sys_set[`SEC_SYS_SERIAL_FAILURE_FLAG_BIT] = (serial_fail_evt | cmd_serial_failure_flag)
                                 & cap_en_q[`SEC_SYS_SERIAL_FAILURE_FLAG_BIT];
    sys_set[`SEC_SYS_WDF_BIT]  = watchdog_fail_evt;
  end

  always_comb begin
    sup_set = 8'h00;
    sup_set[`SEC_SUP_CU_BIT] = sync2_q[1] & supply_capture_en[0];
    sup_set[`SEC_SUP_SU_BIT] = sync2_q[2] & supply_capture_en[1];
    sup_set[`SEC_SUP_SO_BIT] = sync2_q[3] & supply_capture_en[2];
    sup_set = sup_set & sup_mask;
  end

  always_comb begin
    trx_set = 8'h00;
    trx_set[`SEC_TRX_SIL_BIT]   = sync2_q[4] & bus_silence_capture_en;
    trx_set[`SEC_TRX_FAULT_BIT] = sync2_q[5] & trx_fault_capture_en;
    trx_set[`SEC_TRX_WAKE_BIT]  = sync2_q[6] & trx_offline & bus_wake_capture_en;
  end

  always_comb begin
    pin_set = 8'h00;
    pin_set[`SEC_PIN_RISE_BIT] = pin_now & ~pin_prev_q & pin_rise_capture_en;
    pin_set[`SEC_PIN_FALL_BIT] = ~pin_now & pin_prev_q & pin_fall_capture_en;
  end

  assign sys_if.set_evt = sys_set;
  assign sup_if.set_evt = sup_set;
  assign trx_if.set_evt = trx_set;
  assign pin_if.set_evt = pin_set;

  // Clears reach only the defined bits of the addressed register.
  assign sys_if.clr = (reg_wr && reg_addr == `SEC_ADDR_SYS_FLAGS)
                      ? (reg_wdata & `SEC_SYS_MASK) : 8'h00;
  assign sup_if.clr = (reg_wr && reg_addr == `SEC_ADDR_SUP_FLAGS)
                      ? (reg_wdata & sup_mask) : 8'h00;
  assign trx_if.clr = (reg_wr && reg_addr == `SEC_ADDR_TRX_FLAGS)
                      ? (reg_wdata & `SEC_TRX_MASK) : 8'h00;
  assign pin_if.clr = (reg_wr && reg_addr == `SEC_ADDR_PIN_FLAGS)
                      ? (reg_wdata & `SEC_PIN_MASK) : 8'h00;

  always_comb begin
    summary = 8'h00;
    summary[`SEC_SUM_SYS_BIT] = |(sys_if.flags & `SEC_SYS_MASK);
    summary[`SEC_SUM_SUP_BIT] = |(sup_if.flags & sup_mask);
    summary[`SEC_SUM_TRX_BIT] = |(trx_if.flags & `SEC_TRX_MASK);
    summary[`SEC_SUM_PIN_BIT] = |(pin_if.flags & `SEC_PIN_MASK);
  end

  // Read data is registered; writes to the summary are ignored.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SEC_ADDR_SYS_CAP_EN: rdata_q <= cap_en_q;
        `SEC_ADDR_SUMMARY:    rdata_q <= summary;
        `SEC_ADDR_SYS_FLAGS:  rdata_q <= sys_if.flags & `SEC_SYS_MASK;
        `SEC_ADDR_SUP_FLAGS:  rdata_q <= sup_if.flags & sup_mask;
        `SEC_ADDR_TRX_FLAGS:  rdata_q <= trx_if.flags & `SEC_TRX_MASK;
        `SEC_ADDR_PIN_FLAGS:  rdata_q <= pin_if.flags & `SEC_PIN_MASK;
        default:              rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_q <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      sleep_q <= (verdict == SEC_V_SLEEP);
      rst_q   <= (verdict == SEC_V_RESET);
    end
  end

  // The alert only works while the controller is powered to see it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= ~(trx_offline & controller_supply_on & any_pending);
    end
  end

  assign reg_rdata   = rdata_q;
  assign sleep_enter = sleep_q;
  assign reset_enter = rst_q;
  assign rxd         = rxd_q;

  logic sleep_cmd;
  assign sleep_cmd = mode_wr && operating_mode_field == `SEC_MODE_SLEEP;

  AST_NO_WAKE_SRC: assert property (@(posedge clk_sys) disable iff (reset)
    sleep_cmd && !sleep_disable_config && !wake_src_on |=> reset_enter && !sleep_enter)
    else $error("sleep taken with no wake source enabled");

  AST_PENDING_RESET: assert property (@(posedge clk_sys) disable iff (reset)
    sleep_cmd && !sleep_disable_config && any_pending |=> reset_enter && !sleep_enter)
    else $error("sleep taken while an event was pending");

  AST_SLEEP_DISABLED: assert property (@(posedge clk_sys) disable iff (reset)
    sleep_cmd && sleep_disable_config && cap_en_q[1] |=> !sleep_enter && !reset_enter
      && sys_if.flags[`SEC_SYS_SERIAL_FAILURE_FLAG_BIT])
    else $error("disabled sleep not turned into serial failure");

  AST_SLEEP_ONLY_CLEAN: assert property (@(posedge clk_sys) disable iff (reset)
    sleep_enter |-> $past(!sleep_disable_config && wake_src_on && !any_pending && sleep_cmd))
    else $error("sleep entered without all conditions met");

  AST_SUMMARY_RD: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd && reg_addr == `SEC_ADDR_SUMMARY |=> reg_rdata[7:4] == 4'h0
      && reg_rdata[3:0] == $past(summary[3:0]))
    else $error("summary read wrong");

  AST_POWERON: assert property (@(posedge clk_sys) disable iff (reset)
    poweron_evt |=> sys_if.flags[`SEC_SYS_PO_BIT] && summary[`SEC_SUM_SYS_BIT])
    else $error("power-on flag not set");

  AST_OVERHEAT: assert property (@(posedge clk_sys) disable iff (reset)
    overheat_in && cap_en_q[`SEC_SYS_OTW_BIT] ##1 cap_en_q[`SEC_SYS_OTW_BIT] && overheat_in
      ##1 cap_en_q[`SEC_SYS_OTW_BIT] |=> sys_if.flags[`SEC_SYS_OTW_BIT])
    else $error("overheat warning not captured within three cycles");

  AST_WATCHDOG: assert property (@(posedge clk_sys) disable iff (reset)
    watchdog_fail_evt |=> sys_if.flags[`SEC_SYS_WDF_BIT])
    else $error("watchdog failure not captured");

  AST_OFFLINE_WAKE: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(trx_if.flags[0]) && trx_if.flags[0] |-> $past(trx_offline && bus_wake_capture_en))
    else $error("bus wake captured while online or disabled");

  AST_PIN_EDGE: assert property (@(posedge clk_sys) disable iff (reset)
    !pin_rise_capture_en && !pin_if.flags[1] |=> !pin_if.flags[1])
    else $error("rising edge flag set with capture disabled");

  AST_ZERO_KEEPS: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr && reg_addr == `SEC_ADDR_SYS_FLAGS && !reg_wdata[0] && sys_if.flags[0]
      |=> sys_if.flags[0])
    else $error("writing zero cleared a flag");

  AST_ONE_CLEARS: assert property (@(posedge clk_sys) disable iff (reset)
    reg_wr && reg_addr == `SEC_ADDR_PIN_FLAGS && reg_wdata[1] && !pin_set[1]
      |=> !pin_if.flags[1])
    else $error("writing one did not clear a flag");

  AST_DISABLED_OTW: assert property (@(posedge clk_sys) disable iff (reset)
    !cap_en_q[`SEC_SYS_OTW_BIT] && !sys_if.flags[2] |=> !sys_if.flags[2])
    else $error("overheat flag set with capture disabled");

  AST_RXD_ALERT: assert property (@(posedge clk_sys) disable iff (reset)
    trx_offline && controller_supply_on && any_pending |=> !rxd)
    else $error("receive output not pulled low on pending event");

  AST_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
    trx_if.flags[4] && !(reg_wr && reg_addr == `SEC_ADDR_TRX_FLAGS) |=> trx_if.flags[4])
    else $error("silence flag dropped without a clear");

  AST_SERIAL_FAIL: assert property (@(posedge clk_sys) disable iff (reset)
    serial_fail_evt && cap_en_q[`SEC_SYS_SERIAL_FAILURE_FLAG_BIT] |=> sys_if.flags[`SEC_SYS_SERIAL_FAILURE_FLAG_BIT])
    else $error("serial failure not captured");

  AST_SUPPLY_RSVD: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd && reg_addr == `SEC_ADDR_SUP_FLAGS |=> (reg_rdata & ~sup_mask) == 8'h00)
    else $error("reserved supply bit read as one");

  AST_SILENCE: assert property (@(posedge clk_sys) disable iff (reset)
    bus_silence_capture_en && sync2_q[4] |=> trx_if.flags[`SEC_TRX_SIL_BIT])
    else $error("bus silence not captured");

  AST_TRX_FAULT: assert property (@(posedge clk_sys) disable iff (reset)
    trx_fault_capture_en && sync2_q[5] |=> trx_if.flags[`SEC_TRX_FAULT_BIT])
    else $error("transceiver deactivation not captured");

  AST_PIN_FALL: assert property (@(posedge clk_sys) disable iff (reset)
    !pin_fall_capture_en && !pin_if.flags[`SEC_PIN_FALL_BIT]
      |=> !pin_if.flags[`SEC_PIN_FALL_BIT])
    else $error("falling edge flag set with capture disabled");

  AST_CAP_EN_RSVD: assert property (@(posedge clk_sys) disable iff (reset)
    reg_rd && reg_addr == `SEC_ADDR_SYS_CAP_EN |=> (reg_rdata & ~`SEC_CAP_EN_MASK) == 8'h00)
    else $error("reserved capture enable bit read as one");

  AST_RXD_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
    !trx_offline |=> rxd)
    else $error("receive output low while transceiver online");

  AST_SUMMARY_OR: assert property (@(posedge clk_sys) disable iff (reset)
    summary[`SEC_SUM_PIN_BIT] == (pin_if.flags[1] || pin_if.flags[0])
      && summary[`SEC_SUM_TRX_BIT] == (trx_if.flags[4] || trx_if.flags[1] || trx_if.flags[0]))
    else $error("summary bit differs from its flags");

  COV_SLEEP: cover property (@(posedge clk_sys) disable iff (reset) sleep_enter);
  COV_RESET_PENDING: cover property (@(posedge clk_sys) disable iff (reset)
    sleep_cmd && any_pending ##1 reset_enter);
  COV_SERIAL_FAILURE_FLAG_CMD: cover property (@(posedge clk_sys) disable iff (reset) cmd_serial_failure_flag);
  COV_RXD_LOW: cover property (@(posedge clk_sys) disable iff (reset) $fell(rxd));
  COV_NO_WAKE: cover property (@(posedge clk_sys) disable iff (reset)
    sleep_cmd && !wake_src_on ##1 reset_enter);
endmodule
`default_nettype wire

// file: design/sec_consts.svh
// Register offsets, field positions, reset values and codes of the event capture block.
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH
`define SEC_ADDR_SYS_CAP_EN   7'h04
`define SEC_ADDR_SUMMARY      7'h60
`define SEC_ADDR_SYS_FLAGS    7'h61
`define SEC_ADDR_SUP_FLAGS    7'h62
`define SEC_ADDR_TRX_FLAGS    7'h63
`define SEC_ADDR_PIN_FLAGS    7'h64
`define SEC_MODE_SLEEP        3'h1
`define SEC_SYS_PO_BIT        4
`define SEC_SYS_OTW_BIT       2
`define SEC_SYS_SERIAL_FAILURE_FLAG_BIT      1
`define SEC_SYS_WDF_BIT       0
`define SEC_SYS_MASK          8'h17
`define SEC_SUP_SO_BIT        2
`define SEC_SUP_SU_BIT        1
`define SEC_SUP_CU_BIT        0
`define SEC_SUP_MASK_FULL     8'h07
`define SEC_SUP_MASK_BASIC    8'h01
`define SEC_TRX_SIL_BIT       4
`define SEC_TRX_FAULT_BIT     1
`define SEC_TRX_WAKE_BIT      0
`define SEC_TRX_MASK          8'h13
`define SEC_PIN_RISE_BIT      1
`define SEC_PIN_FALL_BIT      0
`define SEC_PIN_MASK          8'h03
`define SEC_CAP_EN_MASK       8'h06
`define SEC_CAP_EN_RESET      8'h00
`define SEC_FLAGS_RESET       8'h00
`define SEC_SUM_PIN_BIT       3
`define SEC_SUM_TRX_BIT       2
`define SEC_SUM_SUP_BIT       1
`define SEC_SUM_SYS_BIT       0
`endif

// file: design/sec_pkg.sv
// Types shared by the event capture block.
package sec_pkg;
  typedef enum logic [1:0] {
    SEC_V_NONE,
    SEC_V_SLEEP,
    SEC_V_RESET,
    SEC_V_SPIFAIL
  } sec_verdict_t;
endpackage

// file: design/sec_flag_if.sv
// Carrier between the event gate and one sticky flag register.
`timescale 1ns/1ns
`default_nettype none
interface sec_flag_if;
  logic [7:0] set_evt;
  logic [7:0] clr;
  logic [7:0] flags;
  modport owner (input set_evt, input clr, output flags);
  modport user (output set_evt, output clr, input flags);
endinterface
`default_nettype wire

// file: design/sec_flag_reg.sv
// One register of sticky event flags, cleared by writing one.
`timescale 1ns/1ns
`default_nettype none
`include "sec_consts.svh"
module sec_flag_reg (
  input  wire logic clk_sys,
  input  wire logic reset,
  sec_flag_if.owner fl
);
  logic [7:0] flags_q;

  // A set in the clearing cycle wins, so no event is lost to a late clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_q <= `SEC_FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~fl.clr) | fl.set_evt;
    end
  end

  assign fl.flags = flags_q;
endmodule
`default_nettype wire

// file: dv/sec_host_model.sv
// Host controller model that drives the register strobe port.
`timescale 1ns/1ns
`default_nettype none
module sec_host_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Idle lines flip so a stale address or datum never passes for a live one.
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Flags are cleared by writing one only to the bits meant to clear.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    @(negedge clk_sys);
    d = reg_rdata;
    // Hand back on a rising edge so the caller's next stimulus lands there.
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: dv/test_sbc_event_capture_sleep_gate.sv
// Self-checking testbench of the event capture and sleep gate block.
`timescale 1ns/1ns
`default_nettype none
module test_sbc_event_capture_sleep_gate;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       mode_wr = 1'b0;
  logic [2:0] mode = 3'h0;
  logic       sdc = 1'b0;
  logic [2:0] evt = 3'h0;
  logic [7:0] lvl = 8'h00;
  logic       offl = 1'b0;
  logic       sup_on = 1'b1;
  logic [2:0] sup_en = 3'h0;
  logic [4:0] en = 5'h00;
  logic       reg_wr;
  logic       reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] basic_rdata;
  logic [7:0] v;
  logic       sleep_enter;
  logic       reset_enter;
  logic       rxd;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  sec_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  sec_event_gate #(.HAS_SENSOR_SUPPLY(1'b1)) dut (.clk_sys(clk_sys), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mode_wr(mode_wr), .operating_mode_field(mode),
    .sleep_disable_config(sdc), .poweron_evt(evt[0]), .watchdog_fail_evt(evt[1]),
    .serial_fail_evt(evt[2]), .overheat_in(lvl[0]), .controller_uv_in(lvl[1]),
    .sensor_ov_in(lvl[2]), .sensor_uv_in(lvl[3]), .bus_silent_in(lvl[4]),
    .trx_deactivated_in(lvl[5]), .bus_wake_in(lvl[6]), .wake_pin(lvl[7]),
    .trx_offline(offl), .controller_supply_on(sup_on), .supply_capture_en(sup_en),
    .bus_silence_capture_en(en[4]), .trx_fault_capture_en(en[3]),
    .bus_wake_capture_en(en[2]), .pin_rise_capture_en(en[1]),
    .pin_fall_capture_en(en[0]), .sleep_enter(sleep_enter),
    .reset_enter(reset_enter), .rxd(rxd));

  // The variant without a sensor supply shares every input and must hide the sensor flags.
  sec_event_gate #(.HAS_SENSOR_SUPPLY(1'b0)) dut_basic (.clk_sys(clk_sys), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(basic_rdata), .mode_wr(mode_wr), .operating_mode_field(mode),
    .sleep_disable_config(sdc), .poweron_evt(evt[0]), .watchdog_fail_evt(evt[1]),
    .serial_fail_evt(evt[2]), .overheat_in(lvl[0]), .controller_uv_in(lvl[1]),
    .sensor_ov_in(lvl[2]), .sensor_uv_in(lvl[3]), .bus_silent_in(lvl[4]),
    .trx_deactivated_in(lvl[5]), .bus_wake_in(lvl[6]), .wake_pin(lvl[7]),
    .trx_offline(offl), .controller_supply_on(sup_on), .supply_capture_en(sup_en),
    .bus_silence_capture_en(en[4]), .trx_fault_capture_en(en[3]),
    .bus_wake_capture_en(en[2]), .pin_rise_capture_en(en[1]),
    .pin_fall_capture_en(en[0]), .sleep_enter(), .reset_enter(), .rxd());

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    host.rd(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_sys) evt[b] <= 1'b1;
    @(posedge clk_sys) evt[b] <= 1'b0;
  endtask

  // Levels pass a two-stage synchroniser, so they are held well past its depth.
  task automatic raise(input int b);
    @(posedge clk_sys) lvl[b] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    lvl[b] <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic sleep_req(input logic [2:0] c, input logic [1:0] exp);
    @(posedge clk_sys);
    mode_wr <= 1'b1;
    mode <= c;
    @(posedge clk_sys);
    mode_wr <= 1'b0;
    @(negedge clk_sys);
    check("sleep,reset", {6'h0, sleep_enter, reset_enter}, {6'h0, exp});
    @(negedge clk_sys);
    check("pulse end", {6'h0, sleep_enter, reset_enter}, 8'h00);
    @(posedge clk_sys);
  endtask

  task automatic t_reset();
    rd_chk(7'h04, 8'h00);
    for (int a = 8'h60; a <= 8'h64; a++) rd_chk(7'(a), 8'h00);
    rd_chk(7'h10, 8'h00);
    check("rxd", {7'h0, rxd}, 8'h01);
    host.wr(7'h04, 8'hff);
    rd_chk(7'h04, 8'h06);
    host.wr(7'h60, 8'hff);
    rd_chk(7'h60, 8'h00);
  endtask

  task automatic t_sys();
    host.wr(7'h04, 8'h00);
    for (int b = 0; b < 3; b++) pulse(b);
    rd_chk(7'h61, 8'h11);
    host.wr(7'h04, 8'h02);
    pulse(2);
    rd_chk(7'h61, 8'h13);
    rd_chk(7'h60, 8'h01);
    host.wr(7'h61, 8'h10);
    rd_chk(7'h61, 8'h03);
    host.wr(7'h61, 8'h03);
    rd_chk(7'h60, 8'h00);
  endtask

  task automatic t_lvl();
    offl <= 1'b1;
    for (int b = 0; b < 8; b++) raise(b);
    for (int a = 8'h61; a <= 8'h64; a++) rd_chk(7'(a), 8'h00);
    host.wr(7'h04, 8'h06);
    sup_en <= 3'h7;
    en <= 5'h1f;
    offl <= 1'b0;
    raise(6);
    rd_chk(7'h63, 8'h00);
    offl <= 1'b1;
    for (int b = 0; b < 8; b++) raise(b);
    rd_chk(7'h61, 8'h04);
    rd_chk(7'h62, 8'h07);
    check("basic supply", basic_rdata, 8'h01);
    rd_chk(7'h63, 8'h13);
    rd_chk(7'h64, 8'h03);
    rd_chk(7'h60, 8'h0f);
    check("rxd", {7'h0, rxd}, 8'h00);
    sup_on <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check("rxd", {7'h0, rxd}, 8'h01);
    @(posedge clk_sys);
    sup_on <= 1'b1;
  endtask

  task automatic t_sleep();
    sleep_req(3'h1, 2'b01);
    for (int a = 8'h61; a <= 8'h64; a++) host.wr(7'(a), 8'hff);
    repeat (2) @(negedge clk_sys);
    check("rxd", {7'h0, rxd}, 8'h01);
    sleep_req(3'h4, 2'b00);
    for (int b = 0; b < 3; b++) begin
      en <= 5'h04 >> b;
      sleep_req(3'h1, 2'b10);
    end
    en <= 5'h18;
    sleep_req(3'h1, 2'b01);
    sdc <= 1'b1;
    sleep_req(3'h1, 2'b00);
    rd_chk(7'h61, 8'h02);
    // The disable bit survives a reset because it lives outside the flags.
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    en <= 5'h1f;
    sleep_req(3'h1, 2'b00);
    rd_chk(7'h61, 8'h00);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_sys();
    t_lvl();
    t_sleep();
    end_of_test();
  end
endmodule
`default_nettype wire
